//--- sadc_ctrl.sv
// Conversion control of the 12-bit successive-approximation converter.
`include "sadc_cfg.svh"
`default_nettype none
module sadc_ctrl #(
  parameter int INT_SRC_CYCLES = `SADC_INT_SRC_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register port.
  input wire sadc_pkg::sadc_req_s req,
  output logic [7:0] rdata,
  // Analog side.
  input wire logic comparator_high,
  output sadc_pkg::sadc_analog_s analog,
  // Clock pins and trigger.
  input wire logic local_async_conv_clock,
  input wire logic external_reference_clock,
  output logic hw_conversion_trigger,
  // Interrupt request to the processor.
  output logic conv_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    sadc_pkg::sadc_state_e state;
    logic complete;
    logic irq_en;
    logic continuous;
    logic [4:0] channel_select;
    logic hw_trig_en;
    logic cmp_en;
    logic cmp_gte;
    logic [7:0] config_reg;
    logic [7:0] pin_enable;
    logic ext_clk_sel;
    logic [2:0] periodic_rate_select;
    logic [11:0] result;
    logic [11:0] cmp_val;
    logic [11:0] sar;
    logic [3:0] bit_idx;
    logic [4:0] smp_cnt;
    logic [1:0] settle;
    logic half_tog;
    logic lp_tog;
    logic [2:0] ack_sync;
    logic [2:0] ref_sync;
    logic [1:0] cmp_sync;
    logic [15:0] int_cnt;
    logic [9:0] periodic_interrupt_counter;
    logic trig;
    logic [7:0] rdata;
  } sadc_st_s;

  sadc_st_s st_q;
  sadc_st_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Lowest bit position converted for a result width.
  function automatic logic [3:0] low_bit(input logic [1:0] mode);
    unique case (sadc_pkg::sadc_width_e'(mode))
      sadc_pkg::SADC_BITS_12: low_bit = 4'h0;
      sadc_pkg::SADC_BITS_10: low_bit = 4'h2;
      sadc_pkg::SADC_BITS_8, sadc_pkg::SADC_BITS_RSVD: low_bit = 4'h4;
    endcase
  endfunction

  // Terminal count of the periodic counter for a rate code.
  function automatic logic [9:0] period_last(input logic [2:0] rate);
    period_last = 10'(({7'h00, 3'h4} << rate) - 10'h001);
  endfunction

  logic [1:0] mode;
  logic [3:0] lsb;
  logic conv_tick_raw;
  logic conv_tick;
  logic per_tick;
  logic per_ovf;
  logic [11:0] final_code;
  logic cmp_true;
  logic sc1_write;
  logic channel_off;
  logic sw_start;
  logic hw_start;

  assign mode = st_q.config_reg[`SADC_CFG_MODE_LSB +: 2];
  assign lsb = low_bit(mode);
  assign channel_off = st_q.channel_select == `SADC_CHAN_DISABLED;
  assign sc1_write = req.wr && req.addr == `SADC_OFS_STATUS_CTRL_1;

  // Conversion clock enable; the alternate input does not exist here, so it never ticks.
  always_comb begin
    unique case (sadc_pkg::sadc_clk_e'(st_q.config_reg[1:0]))
      sadc_pkg::SADC_CLK_BUS: conv_tick_raw = 1'b1;
      sadc_pkg::SADC_CLK_BUS_HALF: conv_tick_raw = st_q.half_tog;
      sadc_pkg::SADC_CLK_ALTERNATE: conv_tick_raw = 1'b0;
      sadc_pkg::SADC_CLK_LOCAL: conv_tick_raw = st_q.ack_sync[1] & ~st_q.ack_sync[2];
    endcase
  end

  // Low-power setting halves the conversion rate, trading speed for supply current.
  assign conv_tick = conv_tick_raw &
                     (st_q.lp_tog | ~st_q.config_reg[`SADC_CFG_LOW_POWER]);

  // Periodic counter source: reference clock edge or internal slow source.
  assign per_tick = st_q.ext_clk_sel ? (st_q.ref_sync[1] & ~st_q.ref_sync[2])
                                     : (st_q.int_cnt == 16'(INT_SRC_CYCLES - 1));
  assign per_ovf = per_tick && st_q.periodic_rate_select != 3'h0 &&
                   st_q.periodic_interrupt_counter == period_last(st_q.periodic_rate_select);

  // Right-justified result of the finished approximation.
  assign final_code = st_q.sar >> lsb;

  // Compare against the programmed value on the justified result.
  assign cmp_true = st_q.cmp_gte ? (final_code >= st_q.cmp_val)
                                 : (final_code < st_q.cmp_val);

  // Start sources; a disabled channel refuses both.
  assign sw_start = sc1_write && !st_q.hw_trig_en &&
                    req.wdata[4:0] != `SADC_CHAN_DISABLED;
  assign hw_start = st_q.trig && st_q.hw_trig_en && !channel_off;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_d = st_q;
    st_d.trig = per_ovf;
    // Synchronisers: only the second stage and its delayed copy are looked at.
    st_d.ack_sync = {st_q.ack_sync[1:0], local_async_conv_clock};
    st_d.ref_sync = {st_q.ref_sync[1:0], external_reference_clock};
    st_d.cmp_sync = {st_q.cmp_sync[0], comparator_high};
    st_d.half_tog = ~st_q.half_tog;
    if (conv_tick_raw) begin
      st_d.lp_tog = ~st_q.lp_tog;
    end
    // Internal slow source and the free-running periodic counter, never gated by power mode.
    if (st_q.int_cnt == 16'(INT_SRC_CYCLES - 1)) begin
      st_d.int_cnt = 16'h0000;
    end else begin
      st_d.int_cnt = st_q.int_cnt + 16'h0001;
    end
    if (per_tick) begin
      if (per_ovf || st_q.periodic_rate_select == 3'h0) begin
        st_d.periodic_interrupt_counter = 10'h000;
      end else begin
        st_d.periodic_interrupt_counter = st_q.periodic_interrupt_counter + 10'h001;
      end
    end
    if (st_q.settle != 2'h0) begin
      st_d.settle = st_q.settle - 2'h1;
    end

    // Sequencer.
    unique case (st_q.state)
      sadc_pkg::SADC_IDLE: begin
        if (hw_start) begin
          st_d.state = sadc_pkg::SADC_SAMPLE;
          st_d.smp_cnt = 5'h00;
        end
      end
      sadc_pkg::SADC_SAMPLE: begin
        if (conv_tick) begin
          st_d.smp_cnt = st_q.smp_cnt + 5'h01;
          if (st_q.smp_cnt == (st_q.config_reg[`SADC_CFG_LONG_SAMPLE] ? `SADC_LONG_SAMPLE
                                                                      : `SADC_SHORT_SAMPLE)
              - 5'h01) begin
            st_d.state = sadc_pkg::SADC_CONVERT;
            st_d.sar = 12'h800;
            st_d.bit_idx = 4'hB;
            st_d.settle = `SADC_SETTLE_CYCLES;
          end
        end
      end
      sadc_pkg::SADC_CONVERT: begin
        // Decide one bit per tick once the comparator path has settled on the trial code.
        if (conv_tick && st_q.settle == 2'h0) begin
          if (!st_q.cmp_sync[1]) begin
            st_d.sar[st_q.bit_idx] = 1'b0;
          end
          if (st_q.bit_idx == lsb) begin
            st_d.state = sadc_pkg::SADC_DONE;
          end else begin
            st_d.bit_idx = st_q.bit_idx - 4'h1;
            st_d.sar[st_q.bit_idx - 4'h1] = 1'b1;
            st_d.settle = `SADC_SETTLE_CYCLES;
          end
        end
      end
      sadc_pkg::SADC_DONE: begin
        st_d.result = final_code;
        if (!st_q.cmp_en || cmp_true) begin
          st_d.complete = 1'b1;
        end
        st_d.smp_cnt = 5'h00;
        if (st_q.continuous && !channel_off) begin
          st_d.state = sadc_pkg::SADC_SAMPLE;
        end else begin
          st_d.state = sadc_pkg::SADC_IDLE;
        end
      end
    endcase

    // Register writes.
    if (req.wr) begin
      unique case (req.addr)
        `SADC_OFS_STATUS_CTRL_1: begin
          st_d.irq_en = req.wdata[`SADC_SC1_IRQ_EN];
          st_d.continuous = req.wdata[`SADC_SC1_CONTINUOUS];
          st_d.channel_select = req.wdata[4:0];
          st_d.state = sw_start ? sadc_pkg::SADC_SAMPLE : sadc_pkg::SADC_IDLE;
          st_d.smp_cnt = 5'h00;
        end
        `SADC_OFS_STATUS_CTRL_2: begin
          st_d.hw_trig_en = req.wdata[`SADC_SC2_HW_TRIG];
          st_d.cmp_en = req.wdata[`SADC_SC2_CMP_EN];
          st_d.cmp_gte = req.wdata[`SADC_SC2_CMP_GTE];
        end
        `SADC_OFS_COMPARE_HI: st_d.cmp_val[11:8] = req.wdata[3:0];
        `SADC_OFS_COMPARE_LO: st_d.cmp_val[7:0] = req.wdata;
        `SADC_OFS_CONFIG: st_d.config_reg = req.wdata;
        `SADC_OFS_PIN_ENABLE: st_d.pin_enable = req.wdata;
        `SADC_OFS_PERIODIC: begin
          st_d.ext_clk_sel = req.wdata[`SADC_PER_EXT_CLK];
          st_d.periodic_rate_select = req.wdata[2:0];
        end
        default: ;
      endcase
    end

    // Completion flag clears on a control write or a low-result read; a set in the same cycle wins.
    if ((sc1_write || (req.rd && req.addr == `SADC_OFS_RESULT_LO)) &&
        !(st_q.state == sadc_pkg::SADC_DONE && (!st_q.cmp_en || cmp_true))) begin
      st_d.complete = 1'b0;
    end

    // Read data, presented in the cycle after the strobe; unmapped offsets read zero.
    st_d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `SADC_OFS_STATUS_CTRL_1: begin
          st_d.rdata = {st_q.complete, st_q.irq_en, st_q.continuous, st_q.channel_select};
        end
        `SADC_OFS_STATUS_CTRL_2: begin
          st_d.rdata = {st_q.state != sadc_pkg::SADC_IDLE, st_q.hw_trig_en, st_q.cmp_en,
                        st_q.cmp_gte, 4'h0};
        end
        `SADC_OFS_RESULT_HI: st_d.rdata = {4'h0, st_q.result[11:8]};
        `SADC_OFS_RESULT_LO: st_d.rdata = st_q.result[7:0];
        `SADC_OFS_COMPARE_HI: st_d.rdata = {4'h0, st_q.cmp_val[11:8]};
        `SADC_OFS_COMPARE_LO: st_d.rdata = st_q.cmp_val[7:0];
        `SADC_OFS_CONFIG: st_d.rdata = st_q.config_reg;
        `SADC_OFS_PIN_ENABLE: st_d.rdata = st_q.pin_enable;
        `SADC_OFS_PERIODIC: st_d.rdata = {3'h0, st_q.ext_clk_sel, 1'b0,
                                          st_q.periodic_rate_select};
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Synchronous reset puts every field at a constant; the channel starts disabled.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.state <= sadc_pkg::SADC_IDLE;
      st_q.channel_select <= `SADC_CHAN_RESET;
      st_q.config_reg <= `SADC_CONFIG_RESET;
      st_q.pin_enable <= `SADC_PIN_EN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Reserved codes pass straight to the multiplexer; their result is whatever comes back.
  assign analog.channel_select = st_q.channel_select;
  assign analog.pin_analog_enable_bit = st_q.pin_enable;
  assign analog.sample = st_q.state == sadc_pkg::SADC_SAMPLE;
  assign analog.trial_code = st_q.sar;
  assign analog.powerdown = channel_off;
  assign analog.active = st_q.state != sadc_pkg::SADC_IDLE;
  assign hw_conversion_trigger = st_q.trig;
  assign conv_irq = st_q.complete & st_q.irq_en;
  assign rdata = st_q.rdata;

endmodule
`default_nettype wire

//--- sadc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
// Register offsets on the plain register port.
`define SADC_OFS_STATUS_CTRL_1 4'h0
`define SADC_OFS_STATUS_CTRL_2 4'h1
`define SADC_OFS_RESULT_HI 4'h2
`define SADC_OFS_RESULT_LO 4'h3
`define SADC_OFS_COMPARE_HI 4'h4
`define SADC_OFS_COMPARE_LO 4'h5
`define SADC_OFS_CONFIG 4'h6
`define SADC_OFS_PIN_ENABLE 4'h7
`define SADC_OFS_PERIODIC 4'h8
// Field positions of status and control 1.
`define SADC_SC1_COMPLETE 7
`define SADC_SC1_IRQ_EN 6
`define SADC_SC1_CONTINUOUS 5
// Field positions of status and control 2.
`define SADC_SC2_ACTIVE 7
`define SADC_SC2_HW_TRIG 6
`define SADC_SC2_CMP_EN 5
`define SADC_SC2_CMP_GTE 4
// Field positions of the configuration register.
`define SADC_CFG_LOW_POWER 7
`define SADC_CFG_LONG_SAMPLE 4
`define SADC_CFG_MODE_LSB 2
// Field positions of the periodic counter register.
`define SADC_PER_EXT_CLK 4
// Reset values and special codes.
`define SADC_CHAN_DISABLED 5'h1F
`define SADC_CHAN_RESET 5'h1F
`define SADC_CONFIG_RESET 8'h00
`define SADC_PIN_EN_RESET 8'h00
// Sample lengths in conversion clock ticks.
`define SADC_SHORT_SAMPLE 5'h04
`define SADC_LONG_SAMPLE 5'h14
// Bus cycles the comparator path needs after each new trial code.
`define SADC_SETTLE_CYCLES 2'h3
// Internal periodic source rate and bus clock rate, both in hertz.
`define SADC_INT_SRC_HZ 1000
`define SADC_CLK_HZ 50000000
`define SADC_INT_SRC_CYCLES (`SADC_CLK_HZ / `SADC_INT_SRC_HZ)
`endif

//--- sadc_pkg.sv
// Types shared by the converter control and its surroundings.
`default_nettype none
package sadc_pkg;
  // Sequencer states, Gray coded along idle, sample, convert, done.
  typedef enum logic [1:0] {
    SADC_IDLE = 2'h0,
    SADC_SAMPLE = 2'h1,
    SADC_CONVERT = 2'h3,
    SADC_DONE = 2'h2
  } sadc_state_e;

  // Conversion clock source codes.
  typedef enum logic [1:0] {
    SADC_CLK_BUS = 2'h0,
    SADC_CLK_BUS_HALF = 2'h1,
    SADC_CLK_ALTERNATE = 2'h2,
    SADC_CLK_LOCAL = 2'h3
  } sadc_clk_e;

  // Result width codes.
  typedef enum logic [1:0] {
    SADC_BITS_8 = 2'h0,
    SADC_BITS_12 = 2'h1,
    SADC_BITS_10 = 2'h2,
    SADC_BITS_RSVD = 2'h3
  } sadc_width_e;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sadc_req_s;

  // Controls toward the analog converter and input multiplexer.
  typedef struct packed {
    logic [4:0] channel_select;
    logic [7:0] pin_analog_enable_bit;
    logic sample;
    logic [11:0] trial_code;
    logic powerdown;
    logic active;
  } sadc_analog_s;
endpackage
`default_nettype wire

//--- sadc_ctrl_asserts.sv
// Port checker of the converter control.
`default_nettype none
module sadc_ctrl_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register port.
  input wire sadc_pkg::sadc_req_s req,
  input wire logic [7:0] rdata,
  // Analog side, trigger and interrupt.
  input wire sadc_pkg::sadc_analog_s analog,
  input wire logic hw_conversion_trigger,
  input wire logic conv_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A clear only counts while idle, since a completion in the same cycle wins.
  wire logic clr = (req.wr && req.addr == 4'h0 || req.rd && req.addr == 4'h3) && !analog.active;
  wire logic sc1_any = req.wr && req.addr == 4'h0;
  wire logic off_wr = sc1_any && req.wdata[4:0] == 5'h1F;
  logic off_seen;
  // Remembers a disable write until the next control write, which may legally start again.
  always_ff @(posedge clk) begin
    if (reset) begin
      off_seen <= 1'b0;
    end else if (sc1_any) begin
      off_seen <= off_wr;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_pd; analog.powerdown == (analog.channel_select == 5'h1F); endproperty
  a_pd: assert property (p_pd) else $error("powerdown does not follow channel");
  property p_off; analog.powerdown |-> !analog.active; endproperty
  a_off: assert property (p_off) else $error("converting while powered down");
  property p_stop; off_seen |-> !analog.active; endproperty
  a_stop: assert property (p_stop) else $error("conversion after disable write");
  property p_unmap; req.rd && req.addr > 4'h8 |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_trig; hw_conversion_trigger |=> !hw_conversion_trigger; endproperty
  a_trig: assert property (p_trig) else $error("trigger longer than one cycle");
  // A control write may cut sampling short at any time, so only other ends are checked.
  property p_samp; $fell(analog.sample) && !$past(sc1_any) |->
    $past(analog.sample, 2) && $past(analog.sample, 3) && $past(analog.sample, 4);
  endproperty
  a_samp: assert property (p_samp) else $error("sample phase too short");
  property p_trial; $fell(analog.sample) && analog.active |-> analog.trial_code == 12'h800;
  endproperty
  a_trial: assert property (p_trial) else $error("first trial not mid-scale");
  property p_clr; clr |=> !conv_irq; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_start; $rose(analog.active) |-> analog.sample && !analog.powerdown; endproperty
  a_start: assert property (p_start) else $error("conversion skipped sampling");
  // Main scenarios reached.
  c_done: cover property ($fell(analog.active));
  c_irq: cover property ($rose(conv_irq));
  c_trig: cover property (hw_conversion_trigger ##[1:20] analog.active);
endmodule

bind sadc_ctrl sadc_ctrl_asserts chk (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
  .analog(analog), .hw_conversion_trigger(hw_conversion_trigger), .conv_irq(conv_irq));
`default_nettype wire

//--- sadc_analog_model.sv
// Behavioural input multiplexer and comparator beside the converter control.
`default_nettype none
module sadc_analog_model #(
  parameter logic [11:0] SUPPLY_LEVEL = 12'hA5C,
  parameter logic [11:0] SENSOR_LEVEL = 12'h3E7,
  parameter logic [11:0] BANDGAP_LEVEL = 12'h2D1
) (
  // Controls from the converter.
  input wire sadc_pkg::sadc_analog_s analog,
  // Comparator result.
  output logic comparator_high
);
  logic [11:0] vin;
  ////////////////////////////////////////////////////////////////////////
  // Pins carry a fixed ramp so that every pin channel gives a distinct code.
  always_comb begin
    case (analog.channel_select) inside
      [5'h00:5'h07]: vin = 12'h123 + 12'(analog.channel_select[2:0]) * 12'h200;
      5'h13: vin = 12'h000;
      [5'h14:5'h19]: vin = SUPPLY_LEVEL;
      5'h1A: vin = SENSOR_LEVEL;
      5'h1B: vin = BANDGAP_LEVEL;
      5'h1C, 5'h1D: vin = 12'hFFF;
      default: vin = 12'h000;
    endcase
  end
  // An isolated input gives nothing usable, so the output toggles with the trial.
  assign comparator_high = analog.powerdown ? ^analog.trial_code
                                            : vin >= analog.trial_code;
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the converter control.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] SENSOR = 12'h3E7;
  localparam logic [11:0] BANDGAP = 12'h2D1;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic local_clk = 1'b0;
  logic ref_clk = 1'b0;
  sadc_pkg::sadc_req_s req = '0;
  sadc_pkg::sadc_analog_s analog;
  logic [7:0] rdata;
  logic comparator_high;
  logic trig;
  logic irq;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // The on-chip oscillator runs free; both extra clocks are unrelated to the bus clock.
  always #10 clk = ~clk;
  always #17.3 local_clk = ~local_clk;
  always #61.7 ref_clk = ~ref_clk;
  sadc_ctrl #(.INT_SRC_CYCLES(10)) uut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .comparator_high(comparator_high), .analog(analog), .local_async_conv_clock(local_clk),
    .external_reference_clock(ref_clk), .hw_conversion_trigger(trig), .conv_irq(irq));
  sadc_analog_model #(.SENSOR_LEVEL(SENSOR), .BANDGAP_LEVEL(BANDGAP)) afe (.analog(analog),
    .comparator_high(comparator_high));
  ////////////////////////////////////////////////////////////////////////
  // Expected code of a pin channel.
  function automatic logic [11:0] pin(input int c);
    return 12'h123 + 12'(c) * 12'h200;
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Waits a bounded time for the interrupt, then compares its level.
  task automatic wait_irq(input int n, input logic e);
    #1;
    for (int i = 0; i < n && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({11'h000, irq}, {11'h000, e});
  endtask
  // Counts trigger pulses over a window of bus cycles.
  task automatic count_trig(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (trig === 1'b1) begin
        k++;
      end
    end
  endtask
  task automatic result(input logic [11:0] e);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(4'h2, hi);
    rd(4'h3, lo);
    chk({hi[3:0], lo}, e);
  endtask
  task automatic conv(input logic [7:0] sc1, input logic [11:0] e);
    wr(4'h0, sc1);
    wait_irq(3000, 1'b1);
    result(e);
  endtask
  task automatic close_out();
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    int k;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Reset values and the space past the last register.
    rd(4'h0, v);
    chk({4'h0, v}, 12'h01F);
    rd(4'h7, v);
    chk({4'h0, v}, 12'h000);
    wr(4'h9, 8'hFF);
    rd(4'h9, v);
    chk({4'h0, v}, 12'h000);
    // Every pin channel at full width on the bus clock.
    wr(4'h7, 8'hFF);
    #1;
    chk({4'h0, analog.pin_analog_enable_bit}, 12'h0FF);
    wr(4'h6, 8'h04);
    for (int c = 0; c < 8; c++) begin
      conv(8'h40 | 8'(c), pin(c));
    end
    // Narrow widths keep the upper bits, right-justified.
    wr(4'h6, 8'h08);
    conv(8'h43, pin(3) >> 2);
    wr(4'h6, 8'h00);
    conv(8'h43, pin(3) >> 4);
    wr(4'h6, 8'h0C);
    conv(8'h43, pin(3) >> 4);
    // Half bus clock, local clock and the slower low-power setting.
    wr(4'h6, 8'h05);
    conv(8'h45, pin(5));
    wr(4'h6, 8'h07);
    conv(8'h44, pin(4));
    wr(4'h6, 8'h84);
    conv(8'h45, pin(5));
    // An abort in mid-conversion leaves the last result in place.
    wr(4'h0, 8'h40);
    repeat (20) @(posedge clk);
    wr(4'h0, 8'h5F);
    wait_irq(300, 1'b0);
    result(pin(5));
    // The absent alternate clock never finishes a conversion.
    wr(4'h6, 8'h06);
    wr(4'h0, 8'h41);
    wait_irq(300, 1'b0);
    wr(4'h0, 8'h5F);
    // Long sample, bandgap first, then the sensor; then a full-scale channel and an unmapped one.
    wr(4'h6, 8'h14);
    conv(8'h5B, BANDGAP);
    conv(8'h5A, SENSOR);
    conv(8'h5D, 12'hFFF);
    conv(8'h48, 12'h000);
    // Compare gates the flag, but the result updates anyway.
    wr(4'h6, 8'h04);
    wr(4'h4, 8'h09);
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h30);
    conv(8'h44, pin(4));
    wr(4'h0, 8'h43);
    wait_irq(300, 1'b0);
    result(pin(3));
    wr(4'h1, 8'h20);
    conv(8'h43, pin(3));
    // Continuous mode restarts by itself until the channel is disabled.
    wr(4'h1, 8'h00);
    conv(8'h62, pin(2));
    wait_irq(300, 1'b1);
    wr(4'h0, 8'h7F);
    wait_irq(300, 1'b0);
    // Periodic counter overflow starts conversions, from either tick source.
    wr(4'h8, 8'h01);
    count_trig(160, k);
    chk(12'(k), 12'h002);
    wr(4'h1, 8'h40);
    conv(8'h46, pin(6));
    wr(4'h8, 8'h11);
    conv(8'h47, pin(7));
    close_out();
  end
endmodule
`default_nettype wire
